// ### rtl/mrd_pkg.sv
/*
 * package for the memory reference decoder: opcodes, mode codes, timing constants.
 * assumes a 200 MHz core clock and a byte-wide core memory port with one cycle per access slot.
 */
package mrd_pkg;
    // clock and memory cycle timing
    localparam int unsigned CLK_PERIOD_PS    = 5000;
    localparam int unsigned MEM_CYCLE_PS     = 1600000;
    localparam int unsigned MEM_CYCLE_CLKS   = (MEM_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned MEM_CNT_W        = 9;
    localparam int unsigned MEM_READ_CLKS    = MEM_CYCLE_CLKS / 2;

    // six-bit opcodes of the group without auto-index
    localparam logic [5:0] OP_INC  = 6'h10;
    localparam logic [5:0] OP_JMP  = 6'h11;
    localparam logic [5:0] OP_AND  = 6'h12;
    localparam logic [5:0] OP_JST  = 6'h13;
    localparam logic [5:0] OP_XOR  = 6'h14;
    localparam logic [5:0] OP_JEI  = 6'h15;
    localparam logic [5:0] OP_OR   = 6'h16;

    // mode bit positions
    localparam int unsigned MODE_IND_BIT  = 0;
    localparam int unsigned MODE_PAGE_BIT = 1;
    localparam int unsigned MODE_AUTO_BIT = 2;

    // reset values
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0]  WR_RESET = 8'h00;

    // instruction classes supplied by the outer decoder
    typedef enum logic [2:0] {
        MRD_CLS_MEMREF  = 3'b000,
        MRD_CLS_AUTOIDX = 3'b001,
        MRD_CLS_MASK    = 3'b010,
        MRD_CLS_SHIFT   = 3'b011,
        MRD_CLS_MINI    = 3'b100
    } mrd_class_t;
endpackage : mrd_pkg

// ### rtl/mrd_cycle_timer.sv
/*
 * memory cycle timer: one-cycle pulse every memory cycle period.
 * assumes it runs on the core clock; the sequencer holds it in reset while idle.
 */
`timescale 1ns/100ps
`default_nettype none
module mrd_cycle_timer
    import mrd_pkg::*;
#(
    parameter int unsigned COUNT = MEM_CYCLE_CLKS
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // control
    input  wire logic run,
    output logic      tick
);
    logic [MEM_CNT_W-1:0] cnt_reg;

    // divider; restarts whenever run drops so each step starts on a whole cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= '0;
        end else if (!run || tick) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign tick = run && (cnt_reg == MEM_CNT_W'(COUNT - 1));
endmodule : mrd_cycle_timer
`default_nettype wire

// ### rtl/mrd_decoder.sv
/*
 * instruction fetch, decode and sequencing for the memory reference group without auto-index,
 * plus mask, shift-count and current-page jump field extraction for other formats.
 * assumes a byte memory that answers every read or write within one memory cycle period.
 */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - second byte is the set/test mask
// - shift count from byte bits 1:0
// - mini instruction jumps within current page
// - fetch two bytes, opcode first
// - each step lasts one 1.6 us cycle
// - indirect adds exactly two memory cycles
// - only listed flags change; decimal flag gated
// - bits 1:0 pick two-bit addressing mode
// - last page slot result undefined
// - AND memory into working, 3/5 cycles
// - OR memory into working, 3/5 cycles
// - open irq gate then branch, 2/4; direct auto-index-class form branches without opening it
// - unconditional branch, 2/4 cycles
// - save return address then branch, 4/6
// - bits 2:0 pick three-bit mode
// - absolute page chosen by region selector
// - post-increment, pre-decrement by operand size
module mrd_decoder
    import mrd_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // control and status
    input  wire logic        run_en,
    input  wire logic        absolute_region_selector,
    input  wire logic        decimal_mode,
    input  wire logic        double_operand,
    input  wire mrd_class_t  instr_class,
    output logic             busy,
    output logic             instr_done,
    output logic             processor_irq_gate,
    input  wire logic        irq_gate_close,
    // architectural state
    output logic [15:0]      pc,
    output logic [7:0]       working_register,
    output logic             result_null_flag,
    output logic             decimal_ok_flag,
    output logic             sum_out_flag,
    // decoded fields for other formats
    output logic [7:0]       bit_mask,
    output logic [2:0]       shift_amount_field,
    // core memory
    output logic             mem_req,
    output logic             mem_we,
    output logic [15:0]      mem_addr,
    output logic [7:0]       mem_wdata,
    input  wire logic [7:0]  mem_rdata
);
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000,
        ST_FOP   = 4'b0001,
        ST_FADR  = 4'b0010,
        ST_PHI   = 4'b0011,
        ST_PLO   = 4'b0100,
        ST_OPRD  = 4'b0101,
        ST_SVHI  = 4'b0111,
        ST_SVLO  = 4'b1000,
        ST_PTWH  = 4'b1001,
        ST_PTWL  = 4'b1010
    } mrd_state_t;

    mrd_state_t  state_reg;
    logic [7:0]  op_reg;
    logic [15:0] pc_reg;
    logic [15:0] instr_pc_reg;
    logic [15:0] ea_reg;
    logic [15:0] ptr_reg;
    logic [15:0] ptr_loc_reg;
    logic [7:0]  wr_reg;
    logic        zero_reg;
    logic        dec_reg;
    logic        irq_reg;
    logic        done_reg;
    logic [7:0]  mask_reg;
    logic [2:0]  shamt_reg;
    logic        tick;
    logic        half_tick;
    logic        rmw_wr_reg;
    logic [1:0]  mode2;
    logic [2:0]  mode3;
    logic        is_auto;
    logic        is_ind;
    logic [15:0] base_addr;
    logic [15:0] step;
    logic [15:0] ptr_new;
    logic [7:0]  alu_res;

    mrd_cycle_timer u_timer (
        .clk   (clk),
        .rst_b (rst_b),
        .run   (state_reg != ST_IDLE),
        .tick  (tick)
    );

    // half-cycle strobe: the increment reads, then restores the new value in one memory cycle
    mrd_cycle_timer #(.COUNT(MEM_READ_CLKS)) u_half (
        .clk   (clk),
        .rst_b (rst_b),
        .run   (state_reg == ST_OPRD && op_reg[7:2] == OP_INC && !rmw_wr_reg),
        .tick  (half_tick)
    );

    // valid decimal test for the decimal flag
    function automatic logic dec_valid(input logic [7:0] v);
        dec_valid = (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9);
    endfunction : dec_valid

    // addressing decode
    assign mode2     = op_reg[1:0];
    assign mode3     = op_reg[2:0];
    assign is_auto   = (instr_class == MRD_CLS_AUTOIDX) && mode3[MODE_AUTO_BIT];
    assign is_ind    = mode2[MODE_IND_BIT] || is_auto;
    // absolute page 0/1 from the selector, else the instruction's own page; valid at the address-byte tick only
    assign base_addr = mode2[MODE_PAGE_BIT] ? {instr_pc_reg[15:8], mem_rdata}
                                            : {7'h00, absolute_region_selector, mem_rdata};
    assign step      = double_operand ? 16'h0002 : 16'h0001;
    assign ptr_new   = mode3[0] ? ptr_reg - step : ptr_reg + step;

    // logic unit for the three boolean ops and increment
    always_comb begin
        unique case (op_reg[7:2])
            OP_AND:  alu_res = wr_reg & mem_rdata;
            OP_OR:   alu_res = wr_reg | mem_rdata;
            OP_XOR:  alu_res = wr_reg ^ mem_rdata;
            default: alu_res = mem_rdata + 8'h01;
        endcase
    end

    // sequencer: one state per memory cycle, so cycle counts follow the state path
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg    <= ST_IDLE;
            op_reg       <= 8'h00;
            pc_reg       <= PC_RESET;
            instr_pc_reg <= PC_RESET;
            ea_reg       <= 16'h0000;
            ptr_reg      <= 16'h0000;
            ptr_loc_reg  <= 16'h0000;
        end else begin
            unique case (state_reg)
                ST_IDLE: if (run_en) begin
                    state_reg    <= ST_FOP;
                    instr_pc_reg <= pc_reg;
                end
                ST_FOP: if (tick) begin
                    op_reg    <= mem_rdata;
                    state_reg <= ST_FADR;
                end
                ST_FADR: if (tick) begin
                    pc_reg    <= instr_pc_reg + 16'h0002;
                    state_reg <= ST_IDLE;
                    if (instr_class == MRD_CLS_MINI) begin
                        pc_reg <= {instr_pc_reg[15:8], mem_rdata};
                    end else if (instr_class == MRD_CLS_MEMREF || instr_class == MRD_CLS_AUTOIDX) begin
                        state_reg <= ST_OPRD;
                    end
                end
                ST_PHI: if (tick) begin
                    ptr_reg[15:8] <= mem_rdata;
                    state_reg     <= ST_PLO;
                end
                ST_PLO: if (tick) begin
                    ptr_reg[7:0] <= mem_rdata;
                    state_reg    <= ST_OPRD;
                end
                default: begin
                end
            endcase
            // after the address byte, resolve the effective address
            if (state_reg == ST_FADR && tick &&
                (instr_class == MRD_CLS_MEMREF || instr_class == MRD_CLS_AUTOIDX)) begin
                ea_reg      <= base_addr;
                ptr_loc_reg <= {base_addr[15:1], 1'b0};
                if (is_ind) begin
                    state_reg <= ST_PHI;
                end else if (op_reg[7:2] == OP_JMP || op_reg[7:2] == OP_JEI) begin
                    pc_reg    <= base_addr;
                    state_reg <= ST_IDLE;
                end else if (op_reg[7:2] == OP_JST) begin
                    state_reg <= ST_SVHI;
                end
            end
            // pointer is ready: pick the operand address
            if (state_reg == ST_PLO && tick) begin
                if (is_auto && mode3[0]) begin
                    ea_reg <= {ptr_reg[15:8], mem_rdata} - step;
                end else begin
                    ea_reg <= {ptr_reg[15:8], mem_rdata};
                end
                if (op_reg[7:2] == OP_JMP || op_reg[7:2] == OP_JEI) begin
                    pc_reg    <= {ptr_reg[15:8], mem_rdata};
                    state_reg <= ST_IDLE;
                end else if (op_reg[7:2] == OP_JST) begin
                    state_reg <= ST_SVHI;
                end
            end
            // operand phase; no page-end wrap fix, the last page slot is undefined
            if (state_reg == ST_OPRD && tick) begin
                state_reg <= is_auto ? ST_PTWH : ST_IDLE;
            end
            if (state_reg == ST_SVHI && tick) begin
                state_reg <= ST_SVLO;
            end
            if (state_reg == ST_SVLO && tick) begin
                pc_reg    <= ea_reg;
                state_reg <= ST_IDLE;
            end
            // auto-index pointer write-back
            if (state_reg == ST_PTWH && tick) begin
                state_reg <= ST_PTWL;
            end
            if (state_reg == ST_PTWL && tick) begin
                state_reg <= ST_IDLE;
            end
        end
    end

    // working register and flags; only boolean ops and increment touch flags
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_reg   <= WR_RESET;
            zero_reg <= 1'b0;
            dec_reg  <= 1'b0;
        end else if (state_reg == ST_OPRD && tick && op_reg[7:2] != OP_INC) begin
            wr_reg   <= alu_res;
            zero_reg <= (alu_res == 8'h00);
            if (decimal_mode) begin
                dec_reg <= dec_valid(alu_res);
            end
        end else if (half_tick) begin
            zero_reg <= (alu_res == 8'h00);
            if (decimal_mode) begin
                dec_reg <= dec_valid(alu_res);
            end
        end
    end

    // increment: read in the first half of the operand cycle, write back in the second
    logic [7:0] wdata_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wdata_reg  <= 8'h00;
            rmw_wr_reg <= 1'b0;
        end else if (half_tick) begin
            wdata_reg  <= alu_res;
            rmw_wr_reg <= 1'b1;
        end else if (tick) begin
            rmw_wr_reg <= 1'b0;
        end
    end

    // irq gate: opened by branch_with_irq_open unless direct in the auto-index class, closed from outside; open wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_reg <= 1'b0;
        end else if ((state_reg == ST_FADR || state_reg == ST_PLO) && tick &&
                     op_reg[7:2] == OP_JEI && !is_ind &&
                     (instr_class == MRD_CLS_MEMREF)) begin
            irq_reg <= 1'b1;
        end else if (state_reg == ST_PLO && tick && op_reg[7:2] == OP_JEI) begin
            irq_reg <= 1'b1;
        end else if (irq_gate_close) begin
            irq_reg <= 1'b0;
        end
    end

    // format fields and completion strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_reg  <= 8'h00;
            shamt_reg <= 3'h0;
            done_reg  <= 1'b0;
        end else begin
            done_reg <= (state_reg != ST_IDLE);         // busy last cycle; done on the first idle one
            if (state_reg == ST_FADR && tick) begin
                if (instr_class == MRD_CLS_MASK) begin
                    mask_reg <= mem_rdata;
                end
                if (instr_class == MRD_CLS_SHIFT) begin
                    shamt_reg <= {1'b0, mem_rdata[1:0]} + 3'h1;
                end
            end
        end
    end

    // memory port: address and data per state
    always_comb begin
        mem_req   = 1'b0;
        mem_we    = 1'b0;
        mem_addr  = 16'h0000;
        mem_wdata = 8'h00;
        unique case (state_reg)
            ST_FOP:  begin mem_req = 1'b1; mem_addr = instr_pc_reg; end
            ST_FADR: begin mem_req = 1'b1; mem_addr = instr_pc_reg + 16'h0001; end
            ST_PHI:  begin mem_req = 1'b1; mem_addr = ptr_loc_reg; end
            ST_PLO:  begin mem_req = 1'b1; mem_addr = ptr_loc_reg + 16'h0001; end
            ST_OPRD: begin mem_req = 1'b1; mem_we = rmw_wr_reg; mem_addr = ea_reg; mem_wdata = wdata_reg; end
            ST_SVHI: begin mem_req = 1'b1; mem_we = 1'b1; mem_addr = ea_reg; mem_wdata = pc_reg[15:8]; end
            ST_SVLO: begin mem_req = 1'b1; mem_we = 1'b1; mem_addr = ea_reg + 16'h0001; mem_wdata = pc_reg[7:0]; end
            ST_PTWH: begin mem_req = 1'b1; mem_we = 1'b1; mem_addr = ptr_loc_reg;
                     mem_wdata = ptr_new[15:8]; end
            ST_PTWL: begin mem_req = 1'b1; mem_we = 1'b1; mem_addr = ptr_loc_reg + 16'h0001;
                     mem_wdata = ptr_new[7:0]; end
            default: begin end
        endcase
    end

    assign busy               = (state_reg != ST_IDLE);
    assign instr_done         = done_reg && (state_reg == ST_IDLE);
    assign processor_irq_gate = irq_reg;
    assign pc                 = pc_reg;
    assign working_register   = wr_reg;
    assign result_null_flag   = zero_reg;
    assign decimal_ok_flag    = dec_reg;
    assign sum_out_flag       = 1'b0;                   // no instruction here changes carry
    assign bit_mask           = mask_reg;
    assign shift_amount_field = shamt_reg;
endmodule : mrd_decoder
`default_nettype wire

// ### testbench/mrd_core_mem.sv
/*
 * behavioural core memory for the decoder bench: byte cells with a slow read access.
 * assumes mem_* stand still for a whole memory cycle and read data is taken at its end.
 */
`timescale 1ns/100ps
`default_nettype none
module mrd_core_mem #(
    parameter int unsigned ACCESS_CLKS = 100
) (
    // clock
    input  wire logic        clk,
    // memory port
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    output logic      [7:0]  mem_rdata
);
    logic [7:0]  cells [0:65535];
    logic [7:0]  last_reg = 8'h00;
    logic [15:0] addr_reg = 16'h0000;
    int unsigned wait_reg = 0;
    logic        ready;
    initial begin
        for (int i = 0; i < 65536; i++) cells[i] = 8'h00;
    end
    // read data only after a steady access, so a decoder that samples early sees junk
    always @(posedge clk) begin
        addr_reg <= mem_addr;
        wait_reg <= (!mem_req || mem_we || mem_addr != addr_reg) ? 0 : wait_reg + 1;
        if (mem_req && mem_we) cells[mem_addr] <= mem_wdata;
        if (ready) last_reg <= cells[mem_addr];
    end
    // outside the valid window the line shows the inverse of the last byte
    assign ready     = mem_req && !mem_we && wait_reg >= ACCESS_CLKS;
    assign mem_rdata = ready ? cells[mem_addr] : ~last_reg;
endmodule : mrd_core_mem
`default_nettype wire

// ### testbench/mrd_decoder_sva.sv
/*
 * port checker for mrd_decoder, bound below.
 * assumes memory cycles follow one another without gaps inside an instruction.
 */
`timescale 1ns/100ps
`default_nettype none
module mrd_decoder_sva
    import mrd_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // control and state
    input wire logic        absolute_region_selector,
    input wire logic        decimal_mode,
    input wire mrd_class_t  instr_class,
    input wire logic        busy,
    input wire logic        instr_done,
    input wire logic        processor_irq_gate,
    input wire logic [15:0] pc,
    input wire logic        result_null_flag,
    input wire logic        decimal_ok_flag,
    input wire logic        sum_out_flag,
    // core memory
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0]  mem_rdata
);
    logic [17:0] sig_reg;
    logic [8:0]  len_reg;
    logic [3:0]  starts_reg, ends_reg;
    logic [15:0] start_reg, ea_direct;
    logic [7:0]  rd_reg, op_reg;
    logic        seg_end, seg_start, idle, is_jump;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    function automatic logic [3:0] memref_cycles(input logic [7:0] op);
        logic [3:0] n;
        case (op[7:2])
            OP_JMP, OP_JEI: n = 4'h2;
            OP_JST:         n = 4'h4;
            default:        n = 4'h3;
        endcase
        return op[MODE_IND_BIT] ? n + 4'h2 : n;
    endfunction : memref_cycles
    // a segment is one steady memory request; read turning to write at one address stays one cycle
    assign seg_end   = sig_reg[17] && ({mem_req, mem_addr} != {sig_reg[17], sig_reg[15:0]});
    assign seg_start = mem_req && (!sig_reg[17] || seg_end);
    assign idle      = !busy && !mem_req;
    assign is_jump   = op_reg[7:2] inside {OP_JMP, OP_JEI, OP_JST};
    // in the done cycle of a direct jump rd_reg still holds the address byte
    assign ea_direct = op_reg[MODE_PAGE_BIT] ? {start_reg[15:8], rd_reg} : {7'h00, absolute_region_selector, rd_reg};
    // segment lengths and counts; cleared while idle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sig_reg    <= '0;
            len_reg    <= '0;
            starts_reg <= '0;
            ends_reg   <= '0;
            rd_reg     <= '0;
        end else begin
            sig_reg    <= {mem_req, mem_we, mem_addr};
            rd_reg     <= mem_rdata;
            len_reg    <= !mem_req ? 9'h000 : seg_start ? 9'h001 : len_reg + 9'h001;
            starts_reg <= idle ? 4'h0 : seg_start ? starts_reg + 4'h1 : starts_reg;
            ends_reg   <= idle ? 4'h0 : seg_end ? ends_reg + 4'h1 : ends_reg;
        end
    end
    // instruction start address, and the opcode byte as read at the end of the first cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start_reg <= '0;
            op_reg    <= '0;
        end else begin
            if (seg_start && starts_reg == 4'h0) start_reg <= mem_addr;
            if (seg_end && ends_reg == 4'h0) op_reg <= rd_reg;
        end
    end
    a_cycle_length: assert property (seg_end |-> len_reg == 9'(MEM_CYCLE_CLKS))
        else $error("memory cycle length wrong");
    a_first_read: assert property ((mem_req && starts_reg == 4'h0) |-> !mem_we)
        else $error("first cycle is not a read");
    a_second_byte: assert property ((seg_end && mem_req && ends_reg == 4'h0) |-> mem_addr == start_reg + 16'h0001)
        else $error("second fetch not at next address");
    a_cycle_count: assert property ((seg_end && !mem_req && instr_class == MRD_CLS_MEMREF)
        |-> starts_reg == memref_cycles(op_reg)) else $error("memory cycle count wrong");
    a_jump_target: assert property ((instr_done && instr_class == MRD_CLS_MEMREF && is_jump
        && op_reg[7:2] != OP_JST && !op_reg[MODE_IND_BIT]) |-> pc == ea_direct) else $error("jump target wrong");
    a_irq_opened: assert property ((instr_done && instr_class == MRD_CLS_MEMREF && op_reg[7:2] == OP_JEI)
        |-> processor_irq_gate) else $error("irq gate not opened");
    a_jump_flags: assert property ((busy && ends_reg != 4'h0 && is_jump)
        |=> $stable({result_null_flag, decimal_ok_flag})) else $error("jump changed a flag");
    a_sum_fixed: assert property ($stable(sum_out_flag))
        else $error("sum flag changed");
    a_decimal_gate: assert property ((!decimal_mode ##1 !decimal_mode) |-> $stable(decimal_ok_flag))
        else $error("decimal flag changed outside decimal mode");
    c_indirect: cover property (instr_done && instr_class == MRD_CLS_MEMREF && op_reg[MODE_IND_BIT]);
    c_save: cover property (instr_done && op_reg[7:2] == OP_JST);
    c_shift: cover property (instr_done && instr_class == MRD_CLS_SHIFT);
endmodule : mrd_decoder_sva
bind mrd_decoder mrd_decoder_sva u_mrd_sva (.clk, .rst_b, .absolute_region_selector, .decimal_mode, .instr_class,
    .busy, .instr_done, .processor_irq_gate, .pc, .result_null_flag, .decimal_ok_flag, .sum_out_flag, .mem_req,
    .mem_we, .mem_addr, .mem_rdata);
`default_nettype wire

// ### testbench/memory_reference_decode_test.sv
/*
 * self-checking bench for mrd_decoder running a short program from the core memory model.
 * assumes the package memory cycle count and a 200 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
module memory_reference_decode_test;
    import mrd_pkg::*;
    logic        clk, rst_b, run_en, absolute_region_selector, decimal_mode, double_operand, irq_gate_close;
    logic        busy, instr_done, processor_irq_gate, result_null_flag, decimal_ok_flag, sum_out_flag;
    logic        mem_req, mem_we;
    logic [15:0] pc, mem_addr, pc_exp;
    logic [7:0]  working_register, bit_mask, mem_wdata, mem_rdata;
    logic [2:0]  shift_amount_field;
    mrd_class_t  instr_class;
    int          n_errors, num_checks;
    // decoder and the core memory behind it
    mrd_decoder dut (.clk, .rst_b, .run_en, .absolute_region_selector, .decimal_mode, .double_operand,
        .instr_class, .busy, .instr_done, .processor_irq_gate, .irq_gate_close, .pc, .working_register,
        .result_null_flag, .decimal_ok_flag, .sum_out_flag, .bit_mask, .shift_amount_field, .mem_req,
        .mem_we, .mem_addr, .mem_wdata, .mem_rdata);
    mrd_core_mem #(.ACCESS_CLKS(150)) mem (.clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata);
    // 200 MHz clock
    always #2.5 clk = ~clk;
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // places one instruction at pc_exp, starts it and waits for completion
    task automatic exec(input logic [7:0] op, input logic [7:0] arg, input mrd_class_t cls);
        int n;
        n = 0;
        mem.cells[pc_exp] = op;
        mem.cells[pc_exp + 16'h0001] = arg;
        @(posedge clk);
        instr_class <= cls;
        run_en      <= 1'b1;
        @(posedge clk);
        run_en      <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (instr_done !== 1'b1 && n < 4000);
        check("instr_done", 16'(instr_done), 16'h0001);
        check("busy_end", 16'(busy), 16'h0000);
        @(negedge clk);
        pc_exp = pc_exp + 16'h0002;
    endtask : exec
    task automatic test_logic();
        mem.cells[16'h0140] = 8'h5A;
        mem.cells[16'h0060] = 8'h12;
        mem.cells[16'h0061] = 8'h34;
        mem.cells[16'h1234] = 8'h0F;
        mem.cells[16'h0142] = 8'h20;
        mem.cells[16'h0143] = 8'h00;
        mem.cells[16'h2000] = 8'h0A;
        exec({OP_OR, 2'b00}, 8'h40, MRD_CLS_MEMREF);
        check("or_working", 16'(working_register), 16'h005A);
        exec({OP_AND, 2'b11}, 8'h60, MRD_CLS_MEMREF);
        check("and_working", 16'(working_register), 16'h000A);
        check("and_null", 16'(result_null_flag), 16'h0000);
        exec({OP_XOR, 2'b01}, 8'h42, MRD_CLS_MEMREF);
        check("xor_working", 16'(working_register), 16'h0000);
        check("xor_null", 16'(result_null_flag), 16'h0001);
    endtask : test_logic
    // decimal mode on: the increment must stay binary
    task automatic test_inc();
        @(posedge clk);
        decimal_mode <= 1'b1;
        mem.cells[16'h0070] = 8'hFF;
        mem.cells[16'h0144] = 8'h09;
        exec({OP_INC, 2'b10}, 8'h70, MRD_CLS_MEMREF);
        check("inc_wrap", 16'(mem.cells[16'h0070]), 16'h0000);
        check("inc_null", 16'(result_null_flag), 16'h0001);
        check("inc_dec_ok", 16'(decimal_ok_flag), 16'h0001);
        exec({OP_INC, 2'b00}, 8'h44, MRD_CLS_MEMREF);
        check("inc_binary", 16'(mem.cells[16'h0144]), 16'h000A);
        check("inc_null_clr", 16'(result_null_flag), 16'h0000);
        check("inc_working", 16'(working_register), 16'h0000);
        check("inc_dec_bad", 16'(decimal_ok_flag), 16'h0000);
        @(posedge clk);
        decimal_mode <= 1'b0;
    endtask : test_inc
    task automatic test_formats();
        for (int nn = 0; nn < 4; nn++) begin
            exec(8'h22, {6'h3F, 2'(nn)}, MRD_CLS_SHIFT);
            check("shift_count", 16'(shift_amount_field), 16'(nn + 1));
        end
        check("pc_sequential", pc, pc_exp);
        exec(8'h28, 8'hA5, MRD_CLS_MASK);
        check("mask", 16'(bit_mask), 16'h00A5);
        exec(8'h30, 8'h30, MRD_CLS_MINI);
        pc_exp = {pc_exp[15:8], 8'h30};
        check("mini_pc", pc, pc_exp);
    endtask : test_formats
    task automatic test_jumps();
        exec({OP_JMP, 2'b00}, 8'h50, MRD_CLS_MEMREF);
        check("jmp_pc", pc, 16'h0150);
        pc_exp = 16'h0150;
        exec({OP_JEI, 2'b10}, 8'h80, MRD_CLS_MEMREF);
        check("jei_pc", pc, 16'h0180);
        check("jei_gate", 16'(processor_irq_gate), 16'h0001);
        check("jump_null", 16'(result_null_flag), 16'h0000);
        check("sum_flag", 16'(sum_out_flag), 16'h0000);
        @(posedge clk);
        irq_gate_close <= 1'b1;
        @(posedge clk);
        irq_gate_close <= 1'b0;
        @(negedge clk);
        check("gate_closed", 16'(processor_irq_gate), 16'h0000);
        pc_exp = 16'h0180;
        exec({OP_JST, 2'b00}, 8'h48, MRD_CLS_MEMREF);
        check("jst_high", 16'(mem.cells[16'h0148]), 16'h0001);
        check("jst_low", 16'(mem.cells[16'h0149]), 16'h0082);
        check("jst_pc", pc, 16'h0148);
    endtask : test_jumps
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    // the program needs about 13k clocks, so 60k means a hang
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        $display("MISMATCH watchdog expected finish seen timeout");
        report_and_stop();
    end
    // reset, then the program in order; pc starts at zero
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        run_en = 1'b0;
        absolute_region_selector = 1'b1;
        decimal_mode = 1'b0;
        double_operand = 1'b0;
        irq_gate_close = 1'b0;
        instr_class = MRD_CLS_MEMREF;
        n_errors = 0;
        num_checks = 0;
        pc_exp = 16'h0000;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        test_logic();
        test_inc();
        test_formats();
        test_jumps();
        report_and_stop();
    end
endmodule : memory_reference_decode_test
`default_nettype wire
